/* File: hw/pss_params.svh */
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSS_CLK_MHZ 100
`define PSS_STABLE_CYCLES 10
`define PSS_CNT_W 4

// ----------------------------------------------------------------
// Lane-rate codes
// ----------------------------------------------------------------
`define PSS_RATE_1G25 2'h0
`define PSS_RATE_2G5 2'h1
`define PSS_RATE_3G125 2'h2
`define PSS_RATE_ILLEGAL 2'h3
`define PSS_RATE_DEFAULT 2'h2

// ----------------------------------------------------------------
// Register map (word offsets in bytes)
// ----------------------------------------------------------------
`define PSS_ADDR_W 4
`define PSS_OFF_CLKSEL 4'h0
`define PSS_OFF_STATUS 4'h4
// Clock selection register fields.
`define PSS_CS_RATE_LSB 0
`define PSS_CS_RATE_MSB 1
`define PSS_CS_PDOVR_BIT 4
`define PSS_CS_PDOVR_EN_BIT 5
// Status register fields.
`define PSS_ST_DONE_BIT 0
`define PSS_ST_ODDPD_BIT 1
`define PSS_ST_EVENPD_BIT 2
`define PSS_ST_MODE_BIT 3
`define PSS_ST_RATE_LSB 4
`define PSS_ST_RATE_MSB 5
`define PSS_ST_ILLEGAL_BIT 6

`endif

/* File: hw/pss_pkg.sv */
package pss_pkg;

    typedef struct packed {
        logic evenPd;
        logic oddPd;
        logic modeSel;
        logic [1:0] rate;
    } pss_straps_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } pss_wb_req_t;

    typedef enum logic [1:0] {
        PSS_RATE_1G25,
        PSS_RATE_2G5,
        PSS_RATE_3G125
    } pss_rate_t;

endpackage : pss_pkg

/* File: hw/pss_capture.sv */
`timescale 1ns/100ps
`include "pss_params.svh"

// ----------------------------------------------------------------
// Stability counter and strap capture, once per reset or self-reset.
// ----------------------------------------------------------------
module pss_capture
    import pss_pkg::*;
#(
    parameter int STABLE_CYCLES = `PSS_STABLE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic selfReset,
    // Straps
    input wire pss_straps_t strapIn,
    // Captured configuration
    output pss_straps_t captured,
    output logic captureDone,
    output logic capturePulse
);

    logic [`PSS_CNT_W-1:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic pulse_reg, pulse_next;
    pss_straps_t cap_reg, cap_next;

    always_comb begin
        cnt_next = cnt_reg;
        done_next = done_reg;
        pulse_next = 1'b0;
        cap_next = cap_reg;
        if (selfReset) begin
            // Self-reset restarts the stability wait and resamples.
            cnt_next = '0;
            done_next = 1'b0;
        end else if (!done_reg) begin
            if (cnt_reg == `PSS_CNT_W'(STABLE_CYCLES - 1)) begin
                cap_next = strapIn;
                done_next = 1'b1;
                pulse_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + `PSS_CNT_W'(1);
            end
        end
        // After capture the strap inputs are not looked at again until a self-reset.
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= '0;
            done_reg <= 1'b0;
            pulse_reg <= 1'b0;
            cap_reg <= '{evenPd: 1'b1, oddPd: 1'b1, modeSel: 1'b0, rate: `PSS_RATE_DEFAULT};
        end else if (clkEn) begin
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            pulse_reg <= pulse_next;
            cap_reg <= cap_next;
        end
    end

    assign captured = cap_reg;
    assign captureDone = done_reg;
    assign capturePulse = pulse_reg;

endmodule : pss_capture

/* File: hw/port_strap_sampler.sv */
// Operation
// - Odd port powered up when its strap samples low, down when high.
// - Software override field replaces the odd-port strap power state.
// - Odd-port strap ignored after its sample until next reset.
// - Strap pins are inputs; output drive only in test mode.
// - Lane code 00=1.25, 01=2.5, 10=3.125 Gbit/s for all ports.
// - Code 10 is default; code 11 illegal and never strapped.
// - Strapped rate applied on hard reset release or self-reset end.
// - Rate strap ignored after reset; software may override rate.
// - Sampled rate strap is the rate field's reset value.
// - Mode strap low gives one four-lane port, high two single-lane ports.
// - Even strap high powers down both ports; low lets odd follow own.
`timescale 1ns/100ps
`include "pss_params.svh"

module port_strap_sampler
    import pss_pkg::*;
#(
    parameter int STABLE_CYCLES = `PSS_STABLE_CYCLES
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic selfReset,
    input wire logic testMode,
    // Strap pins
    input wire logic oddPortPowerdownStrapIn,
    input wire logic evenPortPowerdownStrapIn,
    input wire logic pairModeSelectStrapIn,
    input wire logic [1:0] laneRateStrapIn,
    input wire logic [4:0] strapTestOut,
    output logic [4:0] strapOutEnN,
    output logic [4:0] strapOut,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [`PSS_ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Configuration to MAC and SERDES
    output logic evenPortPowerDown,
    output logic oddPortPowerDown,
    output logic quadLaneMode,
    output logic [1:0] laneRate,
    output logic configValid
);

    pss_straps_t strapIn;
    pss_straps_t captured;
    logic captureDone;
    logic capturePulse;

    assign strapIn = '{evenPd: evenPortPowerdownStrapIn, oddPd: oddPortPowerdownStrapIn,
                       modeSel: pairModeSelectStrapIn, rate: laneRateStrapIn};

    pss_capture #(
        .STABLE_CYCLES(STABLE_CYCLES)
    ) i_pss_capture (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .selfReset(selfReset),
        .strapIn(strapIn),
        .captured(captured),
        .captureDone(captureDone),
        .capturePulse(capturePulse)
    );

    // ----------------------------------------------------------------
    // Rate decode
    // ----------------------------------------------------------------
    // Code 11 is never passed on; it falls back to the default rate.
    function automatic logic [1:0] legalRate(input logic [1:0] code);
        if (code == `PSS_RATE_ILLEGAL) begin
            legalRate = `PSS_RATE_DEFAULT;
        end else begin
            legalRate = code;
        end
    endfunction : legalRate

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0] rate_reg, rate_next;
    logic pdOvr_reg, pdOvr_next;
    logic pdOvrEn_reg, pdOvrEn_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic evenPd_reg, evenPd_next;
    logic oddPd_reg, oddPd_next;
    logic quad_reg, quad_next;
    logic [1:0] outRate_reg, outRate_next;
    logic valid_reg, valid_next;
    logic [4:0] oe_reg, oe_next;
    logic [4:0] pout_reg, pout_next;
    logic wbReq;
    logic lowLane;
    logic cfgReady;

    assign wbReq = wb_cyc_i && wb_stb_i && !ack_reg;
    assign lowLane = wb_sel_i[0];
    // Outputs wait for the cycle after capture, so that the reloaded rate
    // register and the port states become valid together.
    assign cfgReady = captureDone && !capturePulse && !selfReset;

    always_comb begin
        rate_next = rate_reg;
        pdOvr_next = pdOvr_reg;
        pdOvrEn_next = pdOvrEn_reg;
        // A taken request is acked one cycle later; ack drops in the next cycle.
        ack_next = wbReq;
        rdat_next = rdat_reg;
        if (capturePulse) begin
            rate_next = legalRate(captured.rate);
            pdOvrEn_next = 1'b0;
        end
        if (wbReq) begin
            rdat_next = '0;
            unique case (wb_adr_i)
                `PSS_OFF_CLKSEL: begin
                    if (wb_we_i && lowLane) begin
                        rate_next = legalRate(wb_dat_i[`PSS_CS_RATE_MSB:`PSS_CS_RATE_LSB]);
                        pdOvr_next = wb_dat_i[`PSS_CS_PDOVR_BIT];
                        pdOvrEn_next = 1'b1;
                    end
                    rdat_next[`PSS_CS_RATE_MSB:`PSS_CS_RATE_LSB] = rate_reg;
                    rdat_next[`PSS_CS_PDOVR_BIT] = pdOvr_reg;
                    rdat_next[`PSS_CS_PDOVR_EN_BIT] = pdOvrEn_reg;
                end
                `PSS_OFF_STATUS: begin
                    rdat_next[`PSS_ST_DONE_BIT] = captureDone;
                    rdat_next[`PSS_ST_ODDPD_BIT] = captured.oddPd;
                    rdat_next[`PSS_ST_EVENPD_BIT] = captured.evenPd;
                    rdat_next[`PSS_ST_MODE_BIT] = captured.modeSel;
                    rdat_next[`PSS_ST_RATE_MSB:`PSS_ST_RATE_LSB] = captured.rate;
                    rdat_next[`PSS_ST_ILLEGAL_BIT] = (captured.rate == `PSS_RATE_ILLEGAL);
                end
                default: begin
                    // Unmapped offsets read as zero and ignore writes.
                    rdat_next = '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Port configuration
    // ----------------------------------------------------------------
    always_comb begin
        valid_next = cfgReady;
        evenPd_next = captured.evenPd;
        quad_next = cfgReady && !captured.modeSel;
        outRate_next = rate_reg;
        // Odd port uses only the latched copy, never the live pin.
        if (captured.evenPd) begin
            oddPd_next = 1'b1;
        end else if (pdOvrEn_reg) begin
            oddPd_next = pdOvr_reg;
        end else begin
            oddPd_next = captured.oddPd;
        end
        if (!cfgReady) begin
            evenPd_next = 1'b1;
            oddPd_next = 1'b1;
        end
        // Pins drive only in test mode.
        oe_next = testMode ? 5'h0 : 5'h1f;
        pout_next = testMode ? strapTestOut : 5'h0;
    end

    // All state holds while the clock enable is low.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rate_reg <= `PSS_RATE_DEFAULT;
            pdOvr_reg <= 1'b0;
            pdOvrEn_reg <= 1'b0;
            ack_reg <= 1'b0;
            rdat_reg <= '0;
            evenPd_reg <= 1'b1;
            oddPd_reg <= 1'b1;
            quad_reg <= 1'b0;
            outRate_reg <= `PSS_RATE_DEFAULT;
            valid_reg <= 1'b0;
            oe_reg <= 5'h1f;
            pout_reg <= 5'h0;
        end else if (clkEn) begin
            rate_reg <= rate_next;
            pdOvr_reg <= pdOvr_next;
            pdOvrEn_reg <= pdOvrEn_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
            evenPd_reg <= evenPd_next;
            oddPd_reg <= oddPd_next;
            quad_reg <= quad_next;
            outRate_reg <= outRate_next;
            valid_reg <= valid_next;
            oe_reg <= oe_next;
            pout_reg <= pout_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;
    assign evenPortPowerDown = evenPd_reg;
    assign oddPortPowerDown = oddPd_reg;
    assign quadLaneMode = quad_reg;
    assign laneRate = outRate_reg;
    assign configValid = valid_reg;
    assign strapOutEnN = oe_reg;
    assign strapOut = pout_reg;

endmodule : port_strap_sampler

/* File: tb/pss_strap_board.sv */
`timescale 1ns/100ps

module pss_strap_board
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic selfReset,
    // Requested ties
    input wire pss_straps_t want,
    input wire logic breakRules,
    // Device drive in test mode
    input wire logic [4:0] strapOutEnN,
    input wire logic [4:0] strapOut,
    // Resolved strap wires
    output logic [4:0] pins
);
    pss_straps_t tieReg;

    // Ties move only while the device is in reset, unless told to misbehave.
    always @(posedge ref_clk) begin
        if (!rstn || selfReset || breakRules) begin
            tieReg <= want;
            if (!breakRules && !want.modeSel) tieReg.oddPd <= 1'b1;
            if (!breakRules && want.rate == 2'h3) tieReg.rate <= 2'h2;
        end
    end

    assign pins = (strapOutEnN & tieReg) | (~strapOutEnN & strapOut);
endmodule : pss_strap_board

/* File: tb/pss_properties.sv */
`timescale 1ns/100ps

module pss_properties
    import pss_pkg::*;
#(
    parameter int STABLE_CYCLES = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clkEn,
    input wire logic selfReset,
    // Strap pins
    input wire logic testMode,
    input wire logic [4:0] strapOutEnN,
    input wire logic [4:0] strapOut,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Configuration
    input wire logic evenPortPowerDown,
    input wire logic oddPortPowerDown,
    input wire logic [1:0] laneRate,
    input wire logic configValid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic [4:0] relReg;
    logic [4:0] relNext;

    // Counts clock-enabled edges since reset release or the last self-reset request, saturating at 31.
    always_comb begin
        relNext = selfReset ? 5'h00 : (relReg == 5'h1f ? relReg : relReg + 5'h01);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) relReg <= 5'h00;
        else if (clkEn) relReg <= relNext;
    end

    AST_ACK_ONCE: assert property (clkEn && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after the request");
    AST_ACK_DROP: assert property (clkEn && wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_CAPTURE_TIME: assert property ($rose(configValid) |-> relReg == STABLE_CYCLES + 2)
        else $error("configuration valid at the wrong edge");
    AST_PRE_CAPTURE_DOWN: assert property (!configValid |-> evenPortPowerDown && oddPortPowerDown)
        else $error("port powered up before capture");
    AST_EVEN_FORCES_ODD: assert property (evenPortPowerDown |-> oddPortPowerDown)
        else $error("odd port up while even port down");
    AST_RATE_LEGAL: assert property (laneRate != 2'h3)
        else $error("illegal lane rate on output");
    AST_STRAPS_IGNORED: assert property (relReg >= 5'h14 && $changed({laneRate, oddPortPowerDown})
        |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2) || $past(wb_cyc_i, 3))
        else $error("configuration changed without a bus write");
    AST_NO_DRIVE: assert property ($past(clkEn) && !$past(testMode)
        |-> strapOutEnN == 5'h1f && strapOut == 5'h00)
        else $error("strap pin driven outside test mode");
    AST_TEST_DRIVE: assert property ($past(clkEn) && $past(testMode) |-> strapOutEnN == 5'h00)
        else $error("strap pins not driven in test mode");
endmodule : pss_properties

bind port_strap_sampler pss_properties #(.STABLE_CYCLES(STABLE_CYCLES)) i_pss_properties (
    .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .selfReset(selfReset), .testMode(testMode),
    .strapOutEnN(strapOutEnN), .strapOut(strapOut), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .evenPortPowerDown(evenPortPowerDown),
    .oddPortPowerDown(oddPortPowerDown), .laneRate(laneRate), .configValid(configValid));

/* File: tb/test_port_strap_sampler.sv */
`timescale 1ns/100ps

module test_port_strap_sampler import pss_pkg::*;;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic selfReset = 1'b0;
    logic clkEn = 1'b1;
    logic testMode = 1'b0;
    logic breakRules = 1'b0;
    logic wbCyc = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbSel = 4'h0;
    logic [3:0] wbAdr = 4'h0;
    logic [31:0] wbDat = 32'h0000_0000;
    logic [31:0] wbDatO, rdDat;
    logic [4:0] strapTestOut = 5'h00;
    logic [4:0] strapOutEnN, strapOut, pins;
    logic ack, evenPd, oddPd, quad, valid;
    logic [1:0] rate;
    pss_straps_t want = '0;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    pss_strap_board i_pss_strap_board (.ref_clk, .rstn, .selfReset, .want, .breakRules,
        .strapOutEnN, .strapOut, .pins);

    port_strap_sampler #(.STABLE_CYCLES(10)) i_port_strap_sampler (.ref_clk, .rstn,
        .clkEn(clkEn), .selfReset, .testMode, .evenPortPowerdownStrapIn(pins[4]),
        .oddPortPowerdownStrapIn(pins[3]), .pairModeSelectStrapIn(pins[2]),
        .laneRateStrapIn(pins[1:0]), .strapTestOut, .strapOutEnN, .strapOut, .wb_cyc_i(wbCyc),
        .wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
        .wb_dat_o(wbDatO), .wb_ack_o(ack), .evenPortPowerDown(evenPd),
        .oddPortPowerDown(oddPd), .quadLaneMode(quad), .laneRate(rate), .configValid(valid));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] wd);
        wbCyc <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDat <= wd;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        rdDat = wbDatO;
        wbCyc <= 1'b0;
        @(posedge ref_clk);
    endtask : wb

    task test_done;
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        pss_straps_t tbl [4];
        pss_straps_t t;
        logic [31:0] expCfg;
        tbl = '{'{1'b0, 1'b0, 1'b1, 2'h0}, '{1'b0, 1'b1, 1'b1, 2'h1},
            '{1'b0, 1'b1, 1'b0, 2'h2}, '{1'b1, 1'b0, 1'b1, 2'h3}};
        for (int i = 0; i < 4; i++) begin
            t = tbl[i];
            rstn <= 1'b0;
            want <= t;
            breakRules <= (i == 3);
            repeat (10) @(posedge ref_clk);
            check(32'({evenPd, oddPd, valid, rate}), 32'h0000_001a);
            rstn <= 1'b1;
            repeat (14) @(posedge ref_clk);
            expCfg = 32'({t.evenPd, t.oddPd | t.evenPd, !t.modeSel, t.rate == 2'h3 ? 2'h2 : t.rate});
            check(32'({evenPd, oddPd, quad, rate}), expCfg);
            wb(1'b0, 4'h4, 4'hf, 32'h0000_0000);
            check(rdDat, 32'({t.rate == 2'h3, t.rate, t.modeSel, t.evenPd, t.oddPd, 1'b1}));
            wb(1'b0, 4'h0, 4'hf, 32'h0000_0000);
            check(rdDat & 32'h0000_0023, expCfg & 32'h0000_0003);
            want <= ~t;
            breakRules <= 1'b1;
            repeat (20) @(posedge ref_clk);
            check(32'({evenPd, oddPd, quad, rate}), expCfg);
        end
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0011);
        check(32'({oddPd, rate}), 32'h0000_0005);
        wb(1'b1, 4'h0, 4'h0, 32'h0000_0000);
        wb(1'b1, 4'h8, 4'hf, 32'h0000_00ff);
        wb(1'b0, 4'h8, 4'hf, 32'h0000_0000);
        check(rdDat, 32'h0000_0000);
        wb(1'b0, 4'h0, 4'hf, 32'h0000_0000);
        check(rdDat & 32'h0000_003f, 32'h0000_0031);
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0003);
        check(32'(rate), 32'h0000_0002);
        want <= tbl[1];
        breakRules <= 1'b0;
        selfReset <= 1'b1;
        @(posedge ref_clk);
        selfReset <= 1'b0;
        clkEn <= 1'b0;
        repeat (5) @(posedge ref_clk);
        clkEn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        check(32'(valid), 32'h0000_0000);
        repeat (8) @(posedge ref_clk);
        check(32'({valid, oddPd, rate}), 32'h0000_000d);
        wb(1'b0, 4'h0, 4'hf, 32'h0000_0000);
        check(rdDat & 32'h0000_0023, 32'h0000_0001);
        strapTestOut <= 5'h15;
        testMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(32'({strapOutEnN, strapOut}), 32'h0000_0015);
        testMode <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(32'({strapOutEnN, strapOut}), 32'h0000_03e0);
        test_done();
    end
endmodule : test_port_strap_sampler
